//--- core/bytewise_crc_calculator.sv
// Byte-wide CRC calculator with a classic Wishbone register slave
//
// Notes on behaviour
// - Each byte folds into CRC in one step.
// - Three polynomials; code 11 selects CCITT.
// - LSB-first or MSB-first generation is selectable.
// - Input byte register RW; writes fold byte.
// - Result register 16-bit RW, accumulates since clear.
// - Data plus appended code leaves zero result.
// - Eight-bit polynomial result sits in low byte.
// - Control register clears, orders and selects polynomial.
// - Codes: 00 reserved, 01, 10, 11 polynomials.
// - Order bit 0 LSB-first, 1 MSB-first.
// - Writing clear bit 7 zeroes the result.
`timescale 1ns/100ps
`include "crc_defs.svh"

module bytewise_crc_calculator
   import crc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire wb_req_t wb_req_i,
   output wb_rsp_t wb_rsp_o
);

   // ----------------------------------------------------------------
   // Reset state
   // ----------------------------------------------------------------
   localparam crc_state_t STATE_RESET = '{
      ctrl: '{order: `CRC_ORDER_RESET, poly: `CRC_POLY_RESET},
      din: `CRC_INPUT_RESET,
      result: `CRC_RESULT_RESET,
      rsp: '{ack: 1'b0, dat: '0}
   };

   // ----------------------------------------------------------------
   // Parallel byte fold
   // ----------------------------------------------------------------
   // The loop unrolls into one combinational network, so a whole
   // byte is absorbed in a single clock cycle.
   function automatic logic [15:0] crc_fold(
      input logic [15:0] acc,
      input logic [7:0] data,
      input crc_ctrl_t ctrl
   );
      logic [15:0] c;
      logic [15:0] fb16;
      logic [7:0] c8;
      logic [7:0] fb8;
      c = acc;
      c8 = acc[7:0] ^ data;
      fb8 = ctrl.order ? `CRC_FB8_MSB : `CRC_FB8_LSB;
      fb16 = '0;
      unique case (ctrl.poly)
         `CRC_POLY_16_A:
         begin
            fb16 = ctrl.order ? `CRC_FB16A_MSB : `CRC_FB16A_LSB;
         end
         `CRC_POLY_16_B:
         begin
            fb16 = ctrl.order ? `CRC_FB16B_MSB : `CRC_FB16B_LSB;
         end
         default:
         begin
            fb16 = '0;
         end
      endcase
      // Reserved code: the accumulator passes through untouched
      if (ctrl.poly == `CRC_POLY_RESERVED)
      begin
         c = acc;
      end
      else if (ctrl.poly == `CRC_POLY_8)
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (ctrl.order)
            begin
               c8 = c8[7] ? ((c8 << 1) ^ fb8) : (c8 << 1);
            end
            else
            begin
               c8 = c8[0] ? ((c8 >> 1) ^ fb8) : (c8 >> 1);
            end
         end
         // The high byte stays zero for the eight-bit code
         c = {8'h00, c8};
      end
      else if (ctrl.order)
      begin
         c = acc ^ {data, 8'h00};
         for (int i = 0; i < 8; i++)
         begin
            c = c[15] ? ((c << 1) ^ fb16) : (c << 1);
         end
      end
      else
      begin
         c = acc ^ {8'h00, data};
         for (int i = 0; i < 8; i++)
         begin
            c = c[0] ? ((c >> 1) ^ fb16) : (c >> 1);
         end
      end
      return c;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // All block state sits in one struct, registered once
   crc_state_t s_q;
   crc_state_t s_d;
   logic take;
   logic wr;
   logic hit_control;
   logic hit_input;
   logic hit_result;
   logic [`CRC_DAT_W-1:0] rdata;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // A new request is taken only while no answer is standing, so ack
   // lasts exactly one enabled cycle; it holds while ce_i is low.
   assign take = wb_req_i.cyc & wb_req_i.stb & ~s_q.rsp.ack;
   assign wr = take & wb_req_i.we;
   assign hit_control = (wb_req_i.adr == `CRC_OFS_CONTROL);
   assign hit_input = (wb_req_i.adr == `CRC_OFS_INPUT);
   assign hit_result = (wb_req_i.adr == `CRC_OFS_RESULT);

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // The clear bit is write-only and reads as zero.
   // Unmapped offsets read zero but are still acknowledged.
   always_comb
   begin
      rdata = '0;
      if (hit_control)
      begin
         rdata[`CRC_CTL_ORDER_BIT] = s_q.ctrl.order;
         rdata[`CRC_CTL_POLY_HI_BIT] = s_q.ctrl.poly[1];
         rdata[`CRC_CTL_POLY_LO_BIT] = s_q.ctrl.poly[0];
      end
      else if (hit_input)
      begin
         rdata[7:0] = s_q.din;
      end
      else if (hit_result)
      begin
         rdata[15:0] = s_q.result;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.rsp.ack = take;
      s_d.rsp.dat = take ? rdata : '0;
      // A clear and new fields land together in one write
      if (wr && hit_control && wb_req_i.sel[0])
      begin
         s_d.ctrl.order = wb_req_i.dat[`CRC_CTL_ORDER_BIT];
         s_d.ctrl.poly = {wb_req_i.dat[`CRC_CTL_POLY_HI_BIT], wb_req_i.dat[`CRC_CTL_POLY_LO_BIT]};
         if (wb_req_i.dat[`CRC_CTL_CLEAR_BIT])
         begin
            s_d.result = `CRC_RESULT_RESET;
         end
      end
      if (wr && hit_input && wb_req_i.sel[0])
      begin
         // Folds with the polynomial and order already in force
         s_d.din = wb_req_i.dat[7:0];
         s_d.result = crc_fold(s_q.result, wb_req_i.dat[7:0], s_q.ctrl);
      end
      // Each byte lane of the result loads on its own
      if (wr && hit_result)
      begin
         if (wb_req_i.sel[0])
         begin
            s_d.result[7:0] = wb_req_i.dat[7:0];
         end
         if (wb_req_i.sel[1])
         begin
            s_d.result[15:8] = wb_req_i.dat[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= STATE_RESET;
      end
      else if (ce_i)
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   // Ack and read data come straight from flip-flops
   assign wb_rsp_o = s_q.rsp;

endmodule

//--- core/crc_defs.svh
// Register offsets, field positions, encodings and reset values of the byte CRC calculator
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

// ----------------------------------------------------------------
// Bus geometry and register map
// ----------------------------------------------------------------
`define CRC_ADR_W 4
`define CRC_DAT_W 32
`define CRC_SEL_W 4
`define CRC_OFS_CONTROL 4'h0
`define CRC_OFS_INPUT 4'h4
`define CRC_OFS_RESULT 4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CRC_CTL_CLEAR_BIT 7
`define CRC_CTL_ORDER_BIT 2
`define CRC_CTL_POLY_HI_BIT 1
`define CRC_CTL_POLY_LO_BIT 0

// ----------------------------------------------------------------
// Polynomial select codes
// ----------------------------------------------------------------
`define CRC_POLY_RESERVED 2'h0
`define CRC_POLY_8 2'h1
`define CRC_POLY_16_A 2'h2
`define CRC_POLY_16_B 2'h3

// ----------------------------------------------------------------
// Feedback terms: x^8+x^2+x+1, x^16+x^15+x^2+1, x^16+x^12+x^5+1
// ----------------------------------------------------------------
`define CRC_FB8_MSB 8'h07
`define CRC_FB8_LSB 8'hE0
`define CRC_FB16A_MSB 16'h8005
`define CRC_FB16A_LSB 16'hA001
`define CRC_FB16B_MSB 16'h1021
`define CRC_FB16B_LSB 16'h8408

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CRC_RESULT_RESET 16'h0000
`define CRC_INPUT_RESET 8'h00
`define CRC_POLY_RESET 2'h0
`define CRC_ORDER_RESET 1'h0

`endif

//--- core/crc_pkg.sv
// Types shared by the byte CRC calculator and its bench
package crc_pkg;
`include "crc_defs.svh"

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [`CRC_ADR_W-1:0] adr;
      logic [`CRC_SEL_W-1:0] sel;
      logic [`CRC_DAT_W-1:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [`CRC_DAT_W-1:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      logic order;
      logic [1:0] poly;
   } crc_ctrl_t;

   typedef struct packed {
      crc_ctrl_t ctrl;
      logic [7:0] din;
      logic [15:0] result;
      wb_rsp_t rsp;
   } crc_state_t;

endpackage

//--- verif/bytewise_crc_calculator_tb.sv
// Self-checking bench for the byte CRC calculator
`timescale 1ns/100ps

module bytewise_crc_calculator_tb;
   import crc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   wb_req_t req = '0;
   wb_rsp_t rsp;
   logic [15:0] rnd = 16'hFAF6;
   int fails = 0;
   int n_checks = 0;
   int cycles = 0;
   int freeze = 0;

   bytewise_crc_calculator DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(rsp));

   always #4 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ---
   // Classic single Wishbone cycle, entered just after a rising edge
   // ---
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      if (freeze > 0)
      begin
         ce_i <= 1'b0;
         repeat (freeze)
         begin
            @(posedge clk_i);
            chk(32'(rsp.ack), 32'h0);
         end
         ce_i <= 1'b1;
      end
      do @(posedge clk_i); while (rsp.ack !== 1'b1);
      r = rsp.dat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [3:0] a, input int d);
      logic [31:0] r;
      bus(1'b1, a, 32'(d), r);
   endtask

   task automatic rd_chk(input logic [3:0] a, input int e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, 32'(e));
   endtask

   // Reference fold of one byte; p is the polynomial code, o the bit order
   function automatic int fold(int c, int b, int p, int o);
      int m;
      int fb;
      m = (p == 1) ? 16'h00FF : 16'hFFFF;
      fb = o ? (p == 1 ? 8'h07 : p == 2 ? 16'h8005 : 16'h1021) : (p == 1 ? 8'hE0 : p == 2 ? 16'hA001 : 16'h8408);
      if (p == 0)
         return c;
      c = c & m;
      if (o == 0)
      begin
         c = c ^ b;
         repeat (8) c = c[0] ? (c >> 1) ^ fb : c >> 1;
      end
      else
      begin
         c = c ^ (p == 1 ? b : b << 8);
         repeat (8)
         begin
            c = c << 1;
            if (c > m)
               c = (c ^ fb) & m;
         end
      end
      return c & m;
   endfunction

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   initial
   begin
      int c;
      int b;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(4'h0, 0);
      rd_chk(4'h8, 0);
      wr(4'h4, 8'h5A);
      rd_chk(4'h4, 8'h5A);
      rd_chk(4'h8, 0);
      wr(4'h0, 8'h83);
      rd_chk(4'h0, 8'h03);
      wr(4'h4, 8'hF0);
      rd_chk(4'h8, fold(0, 8'hF0, 3, 0));
      wr(4'h4, 8'h8F);
      wr(4'h4, 8'hF7);
      rd_chk(4'h8, 0);
      for (int o = 0; o < 2; o++)
         for (int p = 1; p < 4; p++)
         begin
            wr(4'h0, 8'h80 | o << 2 | p);
            c = 0;
            repeat (3)
            begin
               rnd = lfsr(rnd);
               b = rnd[7:0];
               freeze = rnd[9:8];
               wr(4'h4, b);
               freeze = 0;
               c = fold(c, b, p, o);
               rd_chk(4'h8, c);
            end
            // Append the code in the order the link would carry it
            if (p == 1 || o == 0)
            begin
               wr(4'h4, c & 8'hFF);
               if (p > 1)
                  wr(4'h4, c >> 8);
            end
            else
            begin
               wr(4'h4, c >> 8);
               wr(4'h4, c & 8'hFF);
            end
            rd_chk(4'h8, 0);
            rd_chk(4'h0, o << 2 | p);
         end
      rnd = lfsr(rnd);
      wr(4'h8, rnd);
      rd_chk(4'h8, rnd);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(4'h8, 0);
      rd_chk(4'h4, 0);
      rd_chk(4'h0, 0);
      wr(4'h8, rnd);
      wr(4'h0, 8'h83);
      rd_chk(4'h8, 0);
      rd_chk(4'hC, 0);
      complete_run();
   end
endmodule

//--- verif/crc_calc_props.sv
// Bus timing and register width checks for the byte CRC calculator
`timescale 1ns/100ps

module crc_calc_props
   import crc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire wb_req_t wb_req_i,
   input wire wb_rsp_t wb_rsp_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [1:0] poly_q;
   logic [1:0] poly_d;
   wire rd = wb_rsp_o.ack && !wb_req_i.we;
   wire tk = ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
   // ---
   // Polynomial field as last written
   // ---
   always_comb
   begin
      poly_d = poly_q;
      if (tk && wb_req_i.we && wb_req_i.adr == 4'h0 && wb_req_i.sel[0])
         poly_d = wb_req_i.dat[1:0];
   end
   always_ff @(posedge clk_i)
      poly_q <= rst_i ? 2'h0 : poly_d;
   a_ack_pulse: assert property (wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack)
      else $error("ack longer than one cycle");
   a_ack_next: assert property (tk |=> wb_rsp_o.ack)
      else $error("no ack after request");
   a_ack_unasked: assert property (ce_i && !wb_req_i.stb |=> !wb_rsp_o.ack)
      else $error("ack without request");
   a_idle_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
      else $error("read data outside ack");
   a_ctl_width: assert property (rd && wb_req_i.adr == 4'h0 |-> wb_rsp_o.dat[31:3] == 29'h0)
      else $error("control reads clear bit");
   a_din_width: assert property (rd && wb_req_i.adr == 4'h4 |-> wb_rsp_o.dat[31:8] == 24'h0)
      else $error("input byte too wide");
   a_res_width: assert property (rd && wb_req_i.adr == 4'h8 |-> wb_rsp_o.dat[31:16] == 16'h0)
      else $error("result too wide");
   a_low_byte: assert property (rd && wb_req_i.adr == 4'h8 && poly_q == 2'h1 |-> wb_rsp_o.dat[15:8] == 8'h0)
      else $error("eight bit result not in low byte");
endmodule

bind bytewise_crc_calculator crc_calc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o));
